/* File: scamc_pkg.sv */
package scamc_pkg;

    localparam int          NUM_CH             = 6;
    localparam int          IDX_W              = 7;
    localparam int          DATA_W             = 8;
    localparam logic [6:0]  IDX_CH1_ATTEN      = 7'h01;
    localparam logic [6:0]  IDX_LOAD_RATE_MUTE = 7'h07;
    localparam logic [6:0]  IDX_ENABLE_ZMUTE   = 7'h08;
    localparam logic        RW_WRITE           = 1'b0;
    localparam logic        RW_READ            = 1'b1;
    localparam int          LOAD_EN_BIT        = 7;
    localparam int          RATE_SEL_BIT       = 6;
    localparam int          ZMUTE_EN_BIT       = 6;
    localparam logic [7:0]  ATTEN_RESET        = 8'hff;
    localparam logic [7:0]  ATTEN_INFINITE     = 8'h80;
    localparam logic [7:0]  LOAD_RATE_RESET    = 8'h00;
    localparam logic [7:0]  ENABLE_ZMUTE_RESET = 8'h00;
    localparam logic [7:0]  ENABLE_ZMUTE_MASK  = 8'h7f;
    localparam logic [1:0]  RAMP_FAST_LAST     = 2'h1;
    localparam logic [1:0]  RAMP_SLOW_LAST     = 2'h3;
    localparam logic [1:0]  RAMP_CNT_RESET     = 2'h0;

    typedef struct packed {
        logic       rw;
        logic [6:0] register_index;
        logic [7:0] data;
    } scamc_ctrl_word_t;

    typedef logic [NUM_CH-1:0][DATA_W-1:0] scamc_levels_t;

endpackage

/* File: scamc_atten_regs.sv */
`timescale 1ns/1ps
module scamc_atten_regs (
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic                      ctrl_valid,
    input  wire scamc_pkg::scamc_ctrl_word_t ctrl_word,
    output logic [7:0]                     rd_data,
    output logic                           rd_valid,
    input  wire logic                      sample_strobe,
    input  wire logic                      output_phase_invert,
    input  wire logic [5:0]                zero_detect_in,
    output scamc_pkg::scamc_levels_t       channel_atten_level,
    output logic [5:0]                     channel_disable,
    output logic [5:0]                     zero_mute_out
);
    import scamc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    scamc_levels_t reg_q;
    scamc_levels_t reg_d;
    scamc_levels_t tgt_q;
    scamc_levels_t tgt_d;
    scamc_levels_t cur_q;
    scamc_levels_t cur_d;
    scamc_levels_t goal;
    logic [7:0]    ctl7_q;
    logic [7:0]    ctl7_d;
    logic [7:0]    ctl8_q;
    logic [7:0]    ctl8_d;
    logic [1:0]    cnt_q;
    logic [1:0]    cnt_d;
    logic [7:0]    rd_data_q;
    logic [7:0]    rd_data_d;
    logic          rd_valid_q;
    logic          rd_valid_d;
    logic          wr;
    logic          tick;
    logic          load_en;
    logic          rate_sel;
    logic [5:0]    mute;

    // Folds every code at or below the mute code onto the mute code.
    function automatic logic [7:0] norm_level(input logic [7:0] code);
        norm_level = (code <= ATTEN_INFINITE) ? ATTEN_INFINITE : code;
    endfunction

    // Returns the stored byte for a register index, zero when unmapped.
    function automatic logic [7:0] read_mux(input logic [6:0] idx,
                                            input scamc_levels_t lv,
                                            input logic [7:0] r7,
                                            input logic [7:0] r8);
        read_mux = 8'h00;
        if (idx >= IDX_CH1_ATTEN && idx < IDX_LOAD_RATE_MUTE) begin
            read_mux = lv[3'(idx - IDX_CH1_ATTEN)];
        end else if (idx == IDX_LOAD_RATE_MUTE) begin
            read_mux = r7;
        end else if (idx == IDX_ENABLE_ZMUTE) begin
            read_mux = r8;
        end
    endfunction

    assign load_en  = ctl7_q[LOAD_EN_BIT];
    assign rate_sel = ctl7_q[RATE_SEL_BIT];
    assign mute     = ctl7_q[5:0];
    assign wr       = ctrl_valid && (ctrl_word.rw == RW_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and reads.
    always_comb begin
        reg_d      = reg_q;
        tgt_d      = tgt_q;
        ctl7_d     = ctl7_q;
        ctl8_d     = ctl8_q;
        rd_data_d  = rd_data_q;
        rd_valid_d = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (wr && ctrl_word.register_index == IDX_CH1_ATTEN + 7'(i)) begin
                reg_d[i] = ctrl_word.data;
                if (load_en) begin
                    tgt_d[i] = ctrl_word.data;
                end
            end
        end
        if (wr && ctrl_word.register_index == IDX_LOAD_RATE_MUTE) begin
            ctl7_d = ctrl_word.data;
        end else if (wr && ctrl_word.register_index == IDX_ENABLE_ZMUTE) begin
            ctl8_d = ctrl_word.data & ENABLE_ZMUTE_MASK;
        end
        if (ctrl_valid && ctrl_word.rw == RW_READ) begin
            rd_valid_d = 1'b1;
            rd_data_d  = read_mux(ctrl_word.register_index, reg_q, ctl7_q, ctl8_q);
        end
    end

    // Sample-strobe divider; a rate register write restarts it.
    always_comb begin
        tick  = sample_strobe && (cnt_q == (rate_sel ? RAMP_SLOW_LAST : RAMP_FAST_LAST));
        cnt_d = cnt_q;
        if (wr && ctrl_word.register_index == IDX_LOAD_RATE_MUTE) begin
            cnt_d = RAMP_CNT_RESET;
        end else if (tick) begin
            cnt_d = RAMP_CNT_RESET;
        end else if (sample_strobe) begin
            cnt_d = cnt_q + 2'h1;
        end
    end

    // Each applied level walks one step per tick toward its goal.
    always_comb begin
        cur_d = cur_q;
        for (int i = 0; i < NUM_CH; i++) begin
            goal[i] = mute[i] ? ATTEN_INFINITE : norm_level(tgt_q[i]);
            if (tick && cur_q[i] < goal[i]) begin
                cur_d[i] = cur_q[i] + 8'h01;
            end else if (tick && cur_q[i] > goal[i]) begin
                cur_d[i] = cur_q[i] - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_q      <= {NUM_CH{ATTEN_RESET}};
            tgt_q      <= {NUM_CH{ATTEN_RESET}};
            cur_q      <= {NUM_CH{ATTEN_RESET}};
            ctl7_q     <= LOAD_RATE_RESET;
            ctl8_q     <= ENABLE_ZMUTE_RESET;
            cnt_q      <= RAMP_CNT_RESET;
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            reg_q      <= reg_d;
            tgt_q      <= tgt_d;
            cur_q      <= cur_d;
            ctl7_q     <= ctl7_d;
            ctl8_q     <= ctl8_d;
            cnt_q      <= cnt_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Applied level code: 255 is 0 dB, each step down is 0.5 dB, 128 is mute.
    assign channel_atten_level = cur_q;
    assign channel_disable     = ctl8_q[5:0];
    assign zero_mute_out       = zero_detect_in
                               & {6{ctl8_q[ZMUTE_EN_BIT] & ~output_phase_invert}};
    assign rd_data             = rd_data_q;
    assign rd_valid            = rd_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Helper: strobes seen since the last tick or rate write.
    logic [2:0] seen_q;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            seen_q <= 3'h0;
        end else if (tick || (wr && ctrl_word.register_index == IDX_LOAD_RATE_MUTE)) begin
            seen_q <= 3'h0;
        end else if (sample_strobe && seen_q != 3'h7) begin
            seen_q <= seen_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_wr_ch1;
        ctrl_valid && ctrl_word.rw == RW_WRITE && ctrl_word.register_index == IDX_CH1_ATTEN;
    endsequence

    sequence s_rd_idx8;
        ctrl_valid && ctrl_word.rw == RW_READ && ctrl_word.register_index == IDX_ENABLE_ZMUTE;
    endsequence

    sequence s_wr_ctl7;
        ctrl_valid && ctrl_word.rw == RW_WRITE
            && ctrl_word.register_index == IDX_LOAD_RATE_MUTE;
    endsequence

    sequence s_rd_ch1;
        ctrl_valid && ctrl_word.rw == RW_READ && ctrl_word.register_index == IDX_CH1_ATTEN;
    endsequence

    sequence s_rd_unmapped;
        ctrl_valid && ctrl_word.rw == RW_READ
            && (ctrl_word.register_index == 7'h00 || ctrl_word.register_index > IDX_ENABLE_ZMUTE);
    endsequence

    a_reset_level_ones: assert property (
        $past(!resetn) |-> reg_q == {NUM_CH{ATTEN_RESET}} && cur_q == {NUM_CH{ATTEN_RESET}})
        else $error("Attenuation not at 0 dB after reset.");

    a_load_blocked: assert property (
        s_wr_ch1 and !load_en |=> tgt_q[0] == $past(tgt_q[0]) && reg_q[0] == $past(ctrl_word.data))
        else $error("Channel write applied while load disabled.");

    a_load_applied: assert property (
        s_wr_ch1 and load_en |=> tgt_q[0] == $past(ctrl_word.data))
        else $error("Channel write not applied while load enabled.");

    a_single_step: assert property (
        cur_q[0] != $past(cur_q[0]) |-> $past(tick)
            && (cur_q[0] == $past(cur_q[0]) + 8'h01 || cur_q[0] == $past(cur_q[0]) - 8'h01))
        else $error("Level moved by more than one step or off tick.");

    a_tick_spacing: assert property (
        tick |-> seen_q == (rate_sel ? 3'h3 : 3'h1))
        else $error("Ramp tick spacing wrong for rate select.");

    a_mute_floor: assert property (
        cur_q[0] >= ATTEN_INFINITE)
        else $error("Applied level below mute code.");

    a_mute_descends: assert property (
        mute[0] && tick && cur_q[0] > ATTEN_INFINITE |=> cur_q[0] == $past(cur_q[0]) - 8'h01)
        else $error("Soft mute did not step down.");

    a_unmute_climbs: assert property (
        !mute[0] && tick && cur_q[0] < norm_level(tgt_q[0])
            |=> cur_q[0] == $past(cur_q[0]) + 8'h01)
        else $error("Unmute did not step up.");

    a_zero_mute_gate: assert property (
        output_phase_invert || !ctl8_q[ZMUTE_EN_BIT] |-> zero_mute_out == 6'h00)
        else $error("Zero mute applied while withheld.");

    a_read_back_ctl8: assert property (
        s_rd_idx8 |=> rd_valid && rd_data == $past(ctl8_q))
        else $error("Readback of enable register wrong.");

    a_ctl7_reset: assert property (
        $past(!resetn) |-> ctl7_q == LOAD_RATE_RESET)
        else $error("Load, rate and mute fields not cleared by reset.");

    a_ctl8_reset: assert property (
        $past(!resetn) |-> ctl8_q == ENABLE_ZMUTE_RESET && !rd_valid)
        else $error("Disable and zero mute fields not cleared by reset.");

    a_read_no_write: assert property (
        ctrl_valid && ctrl_word.rw == RW_READ |=> reg_q == $past(reg_q)
            && tgt_q == $past(tgt_q) && ctl7_q == $past(ctl7_q) && ctl8_q == $past(ctl8_q))
        else $error("Read request changed a register.");

    a_read_pulse: assert property (
        ctrl_valid && ctrl_word.rw == RW_READ |=> rd_valid)
        else $error("Read request gave no read pulse.");

    a_idle_no_pulse: assert property (
        !(ctrl_valid && ctrl_word.rw == RW_READ) |=> !rd_valid)
        else $error("Read pulse without a read request.");

    a_ctl7_write: assert property (
        s_wr_ctl7 |=> ctl7_q == $past(ctrl_word.data))
        else $error("Load, rate and mute write not stored.");

    a_ctl8_reserved: assert property (
        ctl8_q[7] == 1'b0)
        else $error("Reserved enable register bit set.");

    a_read_unmapped: assert property (
        s_rd_unmapped |=> rd_valid && rd_data == 8'h00)
        else $error("Unmapped index did not read as zero.");

    a_read_channel1: assert property (
        s_rd_ch1 |=> rd_valid && rd_data == $past(reg_q[0]))
        else $error("Readback of channel level wrong.");

    a_rate_restart: assert property (
        s_wr_ctl7 |=> cnt_q == RAMP_CNT_RESET)
        else $error("Rate write did not restart the divider.");

    a_hold_no_tick: assert property (
        !tick |=> cur_q == $past(cur_q))
        else $error("Applied level moved without a tick.");

    a_goal_holds: assert property (
        tick && cur_q[0] == goal[0] |=> cur_q[0] == $past(cur_q[0]))
        else $error("Applied level left its reached goal.");

    a_zero_mute_pass: assert property (
        ctl8_q[ZMUTE_EN_BIT] && !output_phase_invert |-> zero_mute_out == zero_detect_in)
        else $error("Zero mute not passed while enabled.");

endmodule

/* File: scamc_host.sv */
`timescale 1ns/1ps
// Host side of the control port; it sends control words and audio sample strobes.
module scamc_host (
    input  wire logic                   clk_sys,
    output logic                        ctrl_valid,
    output scamc_pkg::scamc_ctrl_word_t ctrl_word,
    input  wire logic [7:0]             rd_data,
    input  wire logic                   rd_valid,
    output logic                        sample_strobe
);
    import scamc_pkg::*;
    logic [7:0] rd_byte;
    initial begin
        ctrl_valid = 1'b0;
        ctrl_word = '0;
        sample_strobe = 1'b0;
        rd_byte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Sends one word for one rising edge, then scrambles the idle word.
    task automatic send(input logic rw, input logic [6:0] idx, input logic [7:0] dat);
        @(negedge clk_sys);
        ctrl_word = '{rw: rw, register_index: idx, data: dat};
        ctrl_valid = 1'b1;
        @(negedge clk_sys);
        ctrl_valid = 1'b0;
        ctrl_word = ~ctrl_word;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] dat);
        send(RW_WRITE, idx, dat);
    endtask
    // Reads one register and keeps the byte taken with the read pulse.
    task automatic rd(input logic [6:0] idx);
        int n;
        send(RW_READ, idx, 8'h00);
        for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
            @(negedge clk_sys);
        end
        rd_byte = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    endtask
    // Gives n sample strobes, one every second clock.
    task automatic pump(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            sample_strobe = 1'b1;
            @(negedge clk_sys);
            sample_strobe = 1'b0;
        end
    endtask
endmodule

/* File: test_six_channel_attenuator_mute_control.sv */
`timescale 1ns/1ps
module test_six_channel_attenuator_mute_control;
    import scamc_pkg::*;
    logic                   clk_sys = 1'b0;
    logic                   resetn = 1'b0;
    logic                   ctrl_valid;
    scamc_ctrl_word_t       ctrl_word;
    logic [7:0]             rd_data;
    logic                   rd_valid;
    logic                   sample_strobe;
    logic                   output_phase_invert = 1'b0;
    logic [5:0]             zero_detect_in = 6'h00;
    scamc_levels_t          lv;
    logic [5:0]             channel_disable;
    logic [5:0]             zero_mute_out;
    int                     n_errors = 0;
    int                     compares = 0;
    always #2 clk_sys = ~clk_sys;
    scamc_host i_host (.clk_sys(clk_sys), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
        .rd_data(rd_data), .rd_valid(rd_valid), .sample_strobe(sample_strobe));
    scamc_atten_regs i_dut (.clk_sys(clk_sys), .resetn(resetn), .ctrl_valid(ctrl_valid),
        .ctrl_word(ctrl_word), .rd_data(rd_data), .rd_valid(rd_valid),
        .sample_strobe(sample_strobe), .output_phase_invert(output_phase_invert),
        .zero_detect_in(zero_detect_in), .channel_atten_level(lv),
        .channel_disable(channel_disable), .zero_mute_out(zero_mute_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] idx, input logic [7:0] exp);
        i_host.rd(idx);
        chk(i_host.rd_byte, exp);
    endtask
    task automatic strobes(input int n);
        i_host.pump(n);
        @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        for (int i = 1; i <= 6; i++) begin
            rchk(7'(i), ATTEN_RESET);
            chk(lv[i-1], 8'hff);
        end
        rchk(7'h07, 8'h00);
        rchk(7'h08, 8'h00);
        rchk(7'h00, 8'h00);
        i_host.wr(7'h09, 8'h55);
        rchk(7'h09, 8'h00);
        i_host.wr(7'h08, 8'hff);
        rchk(7'h08, 8'h7f);
        chk({2'b00, channel_disable}, 8'h3f);
        zero_detect_in = 6'h3f;
        @(negedge clk_sys);
        chk({2'b00, zero_mute_out}, 8'h3f);
        output_phase_invert = 1'b1;
        @(negedge clk_sys);
        chk({2'b00, zero_mute_out}, 8'h00);
        output_phase_invert = 1'b0;
        i_host.wr(7'h08, 8'h00);
        chk({2'b00, zero_mute_out}, 8'h00);
        i_host.wr(7'h01, 8'hfd);
        strobes(8);
        rchk(7'h01, 8'hfd);
        chk(lv[0], 8'hff);
        i_host.wr(7'h07, 8'h80);
        strobes(4);
        chk(lv[0], 8'hff);
        i_host.wr(7'h01, 8'hfd);
        strobes(2);
        chk(lv[0], 8'hfe);
        strobes(2);
        chk(lv[0], 8'hfd);
        i_host.wr(7'h07, 8'hc0);
        i_host.wr(7'h02, 8'hfe);
        strobes(3);
        chk(lv[1], 8'hff);
        strobes(1);
        chk(lv[1], 8'hfe);
        i_host.wr(7'h07, 8'h81);
        strobes(2);
        chk(lv[0], 8'hfc);
        i_host.wr(7'h03, 8'h05);
        strobes(300);
        chk(lv[0], ATTEN_INFINITE);
        chk(lv[2], ATTEN_INFINITE);
        rchk(7'h07, 8'h81);
        i_host.wr(7'h07, 8'h80);
        i_host.wr(7'h04, 8'h81);
        strobes(300);
        chk(lv[0], 8'hfd);
        chk(lv[2], ATTEN_INFINITE);
        chk(lv[3], 8'h81);
        test_done();
    end
endmodule
